// ==== bbo_alu.sv ====
// combinational arithmetic/logic unit for add, and, bit clear, bit set
// assumes operands settle within one core clock
`timescale 1ns/1ps
`default_nettype none
module bbo_alu (
  input wire bbo_pkg::bbo_alu_op_t i_op,
  input wire logic [bbo_pkg::DW-1:0] i_a,
  input wire logic [bbo_pkg::DW-1:0] i_b,
  input wire logic [2:0] i_bit_sel,
  output bbo_pkg::bbo_alu_t o_out
);

  logic [bbo_pkg::DW:0] sum;
  logic [bbo_pkg::NIB_W:0] nib;
  logic [bbo_pkg::DW-1:0] mask;

  always_comb begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    nib = {1'b0, i_a[bbo_pkg::NIB_W-1:0]} + {1'b0, i_b[bbo_pkg::NIB_W-1:0]};
    mask = bbo_pkg::BIT0 << i_bit_sel;
    case (i_op)
      bbo_pkg::ALU_ADD: o_out.res = sum[bbo_pkg::DW-1:0];
      bbo_pkg::ALU_AND: o_out.res = i_a & i_b;
      bbo_pkg::ALU_CLR: o_out.res = i_b & ~mask;
      default: o_out.res = i_b | mask;
    endcase
    o_out.carry = sum[bbo_pkg::DW];
    o_out.dcarry = nib[bbo_pkg::NIB_W];
    o_out.zero = (o_out.res == bbo_pkg::ZERO_BYTE);
  end

endmodule // bbo_alu
`default_nettype wire

// ==== bbo_datapath.sv ====
// byte and bit operation datapath: accumulator, flags, file registers
// assumes commands and bus strobes come from logic on i_mclk
`timescale 1ns/1ps
`default_nettype none
module bbo_datapath #(
  parameter int PRESC_W = bbo_pkg::PRESC_W_DEF
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire bbo_pkg::bbo_cmd_t i_cmd,
  input wire logic [bbo_pkg::BUS_AW-1:0] i_addr,
  input wire logic [bbo_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [bbo_pkg::DW-1:0] i_io_pins,
  output logic [bbo_pkg::DW-1:0] o_rdata,
  output logic [bbo_pkg::DW-1:0] o_acc,
  output logic o_carry,
  output logic o_dcarry,
  output logic o_zero,
  output logic o_skip,
  output logic [bbo_pkg::DW-1:0] o_io_latch,
  output logic [bbo_pkg::DW-1:0] o_timer
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchroniser

  logic rst_meta_q;
  logic rst_n;
  logic [bbo_pkg::DW-1:0] pin_meta_q;
  logic [bbo_pkg::DW-1:0] pin_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= bbo_pkg::ZERO_BYTE;
      pin_q <= bbo_pkg::ZERO_BYTE;
    end else begin
      pin_meta_q <= i_io_pins;
      pin_q <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and operand fetch

  logic exec;
  logic is_lit;
  logic is_add;
  logic is_and;
  logic is_bitop;
  logic file_wr;
  logic acc_wr;
  logic tested_bit;
  logic psa_q;
  logic [PRESC_W-1:0] presc_q;
  logic [bbo_pkg::DW-1:0] file_val;
  logic [bbo_pkg::DW-1:0] ram_rd_a;
  logic [bbo_pkg::DW-1:0] ram_rd_b;
  bbo_pkg::bbo_alu_op_t alu_op;
  bbo_pkg::bbo_alu_t alu;

  // a command arriving while skip is pending becomes a no-operation
  assign exec = i_cmd_valid && !o_skip;
  assign is_lit = (i_cmd.op == bbo_pkg::OP_ADD_LIT) || (i_cmd.op == bbo_pkg::OP_AND_LIT);
  assign is_add = (i_cmd.op == bbo_pkg::OP_ADD_LIT) || (i_cmd.op == bbo_pkg::OP_ADD_FILE);
  assign is_and = (i_cmd.op == bbo_pkg::OP_AND_LIT) || (i_cmd.op == bbo_pkg::OP_AND_FILE);
  assign is_bitop = (i_cmd.op == bbo_pkg::OP_BIT_CLR) || (i_cmd.op == bbo_pkg::OP_BIT_SET);

  always_comb begin
    if (i_cmd.addr == bbo_pkg::FILE_IO) begin
      file_val = pin_q;
    end else if (i_cmd.addr == bbo_pkg::FILE_TIMER) begin
      file_val = o_timer;
    end else begin
      file_val = ram_rd_a;
    end
  end

  always_comb begin
    case (i_cmd.op)
      bbo_pkg::OP_AND_LIT, bbo_pkg::OP_AND_FILE: alu_op = bbo_pkg::ALU_AND;
      bbo_pkg::OP_BIT_CLR: alu_op = bbo_pkg::ALU_CLR;
      bbo_pkg::OP_BIT_SET: alu_op = bbo_pkg::ALU_SET;
      default: alu_op = bbo_pkg::ALU_ADD;
    endcase
  end

  bbo_alu u_alu (
    .i_op(alu_op),
    .i_a(o_acc),
    .i_b(is_lit ? i_cmd.literal : file_val),
    .i_bit_sel(i_cmd.bit_sel),
    .o_out(alu)
  );

  assign tested_bit = file_val[i_cmd.bit_sel];
  assign file_wr = exec && (is_bitop
    || ((i_cmd.op == bbo_pkg::OP_ADD_FILE || i_cmd.op == bbo_pkg::OP_AND_FILE)
        && i_cmd.dest == bbo_pkg::DEST_FILE));
  assign acc_wr = exec && (is_lit
    || ((i_cmd.op == bbo_pkg::OP_ADD_FILE || i_cmd.op == bbo_pkg::OP_AND_FILE)
        && i_cmd.dest == bbo_pkg::DEST_ACC));

  ////////////////////////////////////////////////////////////////////////////
  // file register writes: command has priority over the bus

  logic bus_file;
  logic wr_any;
  logic [bbo_pkg::FILE_AW-1:0] wr_addr;
  logic [bbo_pkg::DW-1:0] wr_data;

  assign bus_file = !i_addr[bbo_pkg::BUS_FILE_SEL];
  assign wr_any = file_wr || (i_wr && bus_file);
  assign wr_addr = file_wr ? i_cmd.addr : i_addr[bbo_pkg::FILE_AW-1:0];
  assign wr_data = file_wr ? alu.res : i_wdata;

  bbo_file_ram u_ram (
    .i_mclk(i_mclk),
    .i_we(wr_any && wr_addr != bbo_pkg::FILE_IO && wr_addr != bbo_pkg::FILE_TIMER),
    .i_waddr(wr_addr),
    .i_wdata(wr_data),
    .i_raddr_a(i_cmd.addr),
    .i_raddr_b(i_addr[bbo_pkg::FILE_AW-1:0]),
    .o_rdata_a(ram_rd_a),
    .o_rdata_b(ram_rd_b)
  );

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_io_latch <= bbo_pkg::IO_LATCH_RST;
    end else if (wr_any && wr_addr == bbo_pkg::FILE_IO) begin
      o_io_latch <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer and prescaler

  logic timer_wr;

  assign timer_wr = wr_any && wr_addr == bbo_pkg::FILE_TIMER;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else if (!psa_q || timer_wr) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_timer <= bbo_pkg::TIMER_RST;
    end else if (timer_wr) begin
      o_timer <= wr_data;
    end else if (!psa_q || &presc_q) begin
      o_timer <= o_timer + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator, flags, config, skip

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_acc <= bbo_pkg::ACC_RST;
    end else if (acc_wr) begin
      o_acc <= alu.res;
    end else if (i_wr && i_addr == bbo_pkg::ADDR_ACC) begin
      o_acc <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_carry <= 1'b0;
      o_dcarry <= 1'b0;
      o_zero <= 1'b0;
    end else if (exec && is_add) begin
      o_carry <= alu.carry;
      o_dcarry <= alu.dcarry;
      o_zero <= alu.zero;
    end else if (exec && is_and) begin
      o_zero <= alu.zero;
    end else if (i_wr && i_addr == bbo_pkg::ADDR_STATUS) begin
      o_carry <= i_wdata[bbo_pkg::STAT_C];
      o_dcarry <= i_wdata[bbo_pkg::STAT_DCARRY];
      o_zero <= i_wdata[bbo_pkg::STAT_Z];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      psa_q <= 1'b0;
    end else if (i_wr && i_addr == bbo_pkg::ADDR_CFG) begin
      psa_q <= i_wdata[bbo_pkg::CFG_PSA];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_skip <= 1'b0;
    end else if (exec && i_cmd.op == bbo_pkg::OP_BIT_TEST && !tested_bit) begin
      o_skip <= 1'b1;
    end else if (i_cmd_valid) begin
      o_skip <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read data, one cycle after the strobe

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= bbo_pkg::ZERO_BYTE;
    end else if (!i_rd) begin
      o_rdata <= bbo_pkg::ZERO_BYTE;
    end else if (bus_file && i_addr[bbo_pkg::FILE_AW-1:0] == bbo_pkg::FILE_IO) begin
      o_rdata <= pin_q;
    end else if (bus_file && i_addr[bbo_pkg::FILE_AW-1:0] == bbo_pkg::FILE_TIMER) begin
      o_rdata <= o_timer;
    end else if (bus_file) begin
      o_rdata <= ram_rd_b;
    end else if (i_addr == bbo_pkg::ADDR_ACC) begin
      o_rdata <= o_acc;
    end else if (i_addr == bbo_pkg::ADDR_STATUS) begin
      o_rdata <= {5'h00, o_zero, o_dcarry, o_carry};
    end else if (i_addr == bbo_pkg::ADDR_CFG) begin
      o_rdata <= {7'h00, psa_q};
    end else begin
      o_rdata <= bbo_pkg::ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence s_skip_armed;
    exec && i_cmd.op == bbo_pkg::OP_BIT_TEST && !tested_bit;
  endsequence

  // a bus write may still land beside a discarded command
  sequence s_discard;
    o_skip && i_cmd_valid && !i_wr;
  endsequence

  add_literal_acc_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_ADD_LIT |=>
      o_acc == 8'($past(o_acc) + $past(i_cmd.literal)))
    else $error("literal add result wrong");

  bit_clear_io_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_BIT_CLR && i_cmd.addr == bbo_pkg::FILE_IO |=>
      o_io_latch[$past(i_cmd.bit_sel)] == 1'b0 && $stable(o_zero) && $stable(o_carry))
    else $error("bit clear failed or touched flags");

  bit_set_io_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_BIT_SET && i_cmd.addr == bbo_pkg::FILE_IO |=>
      o_io_latch[$past(i_cmd.bit_sel)] == 1'b1 && $stable(o_dcarry))
    else $error("bit set failed or touched flags");

  add_file_acc_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_ADD_FILE && i_cmd.dest == bbo_pkg::DEST_ACC |=>
      o_acc == 8'($past(o_acc) + $past(file_val)))
    else $error("file add to accumulator wrong");

  and_literal_flags_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_AND_LIT |=>
      o_acc == ($past(o_acc) & $past(i_cmd.literal)) && $stable(o_carry)
      && o_zero == (o_acc == bbo_pkg::ZERO_BYTE))
    else $error("literal and wrong");

  skip_next_a: assert property (
    s_skip_armed |=> o_skip)
    else $error("skip not armed by clear bit");

  skip_discard_a: assert property (
    s_discard |=> !o_skip && $stable(o_acc) && $stable(o_zero))
    else $error("skip did not discard next command");

  and_file_dest_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_AND_FILE && i_cmd.dest == bbo_pkg::DEST_FILE
      && i_cmd.addr == bbo_pkg::FILE_IO |=>
      o_io_latch == ($past(o_acc) & $past(pin_q)) && $stable(o_acc))
    else $error("file and to register wrong");

  io_from_pins_a: assert property (
    exec && i_cmd.op == bbo_pkg::OP_ADD_FILE && i_cmd.dest == bbo_pkg::DEST_FILE
      && i_cmd.addr == bbo_pkg::FILE_IO |=>
      o_io_latch == 8'($past(o_acc) + $past(pin_q)))
    else $error("io operand not taken from pins");

  presc_clear_a: assert property (
    file_wr && i_cmd.addr == bbo_pkg::FILE_TIMER |=> presc_q == '0)
    else $error("prescaler not cleared on timer write");

  zero_flag_a: assert property (
    exec && (is_add || is_and) |=> o_zero == ($past(alu.res) == bbo_pkg::ZERO_BYTE))
    else $error("zero flag wrong");

endmodule // bbo_datapath
`default_nettype wire

// ==== bbo_datapath_tb.sv ====
// self-checking testbench of the byte/bit operation datapath
// assumes bbo_pkg, bbo_alu, bbo_file_ram and bbo_datapath are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PW = 2;
  logic mclk;
  logic nrst;
  logic cmd_valid;
  logic wr;
  logic rd;
  logic carry;
  logic dcarry;
  logic zero;
  logic skip;
  bbo_pkg::bbo_cmd_t cmd_in;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] io_pins;
  logic [7:0] rdata;
  logic [7:0] acc;
  logic [7:0] io_latch;
  logic [7:0] timer;
  logic [7:0] v;
  logic [7:0] a;
  logic [7:0] k;
  logic [7:0] e;
  logic [8:0] s;
  logic [4:0] n;
  logic [7:0] ta [4] = '{8'h8F, 8'h00, 8'h01, 8'h7F};
  logic [7:0] tk [4] = '{8'h71, 8'h00, 8'hFF, 8'h01};
  int n_errors = 0;
  int checked = 0;

  bbo_datapath #(.PRESC_W(PW)) i_dut (
    .i_mclk(mclk), .i_nrst(nrst), .i_cmd_valid(cmd_valid), .i_cmd(cmd_in),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_io_pins(io_pins),
    .o_rdata(rdata), .o_acc(acc), .o_carry(carry), .o_dcarry(dcarry), .o_zero(zero),
    .o_skip(skip), .o_io_latch(io_latch), .o_timer(timer)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] flg();
    return {5'h00, zero, dcarry, carry};
  endfunction

  task automatic wr_bus(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_bus(input logic [7:0] ad, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic op(input bbo_pkg::bbo_op_t o, input logic [6:0] fa, input logic [2:0] b,
                    input logic d, input logic [7:0] lit);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_in <= '{op: o, addr: fa, bit_sel: b, dest: d, literal: lit};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog well beyond the nearly two hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_in = '0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    io_pins = 8'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("acc reset", acc, bbo_pkg::ACC_RST);
    chk("flags reset", flg(), 8'h00);
    wr_bus(8'h90, 8'h5A);
    rd_bus(8'h90, v);
    chk("unmapped read", v, 8'h00);
    wr_bus(bbo_pkg::ADDR_ACC, 8'h3C);
    rd_bus(bbo_pkg::ADDR_ACC, v);
    chk("acc read", v, 8'h3C);
    @(posedge mclk);
    #1;
    chk("rdata drop", rdata, 8'h00);
    // literal add, carry and zero corners
    for (int i = 0; i < 4; i++) begin
      a = ta[i];
      k = tk[i];
      wr_bus(bbo_pkg::ADDR_ACC, a);
      op(bbo_pkg::OP_ADD_LIT, 7'h00, 3'h0, bbo_pkg::DEST_ACC, k);
      s = {1'b0, a} + {1'b0, k};
      n = {1'b0, a[3:0]} + {1'b0, k[3:0]};
      chk("add lit acc", acc, s[7:0]);
      chk("add lit flags", flg(), {5'h00, s[7:0] == 8'h00, n[4], s[8]});
    end
    // literal and keeps carry and digit carry
    wr_bus(bbo_pkg::ADDR_STATUS, 8'h03);
    wr_bus(bbo_pkg::ADDR_ACC, 8'hF0);
    op(bbo_pkg::OP_AND_LIT, 7'h00, 3'h0, bbo_pkg::DEST_ACC, 8'h0F);
    chk("and lit acc", acc, 8'h00);
    chk("and lit flags", flg(), 8'h07);
    wr_bus(bbo_pkg::ADDR_ACC, 8'hF0);
    op(bbo_pkg::OP_AND_LIT, 7'h00, 3'h0, bbo_pkg::DEST_ACC, 8'h3C);
    chk("and lit acc", acc, 8'h30);
    chk("and lit flags", flg(), 8'h03);
    // file add to each destination
    wr_bus(8'h20, 8'h28);
    wr_bus(bbo_pkg::ADDR_ACC, 8'h19);
    op(bbo_pkg::OP_ADD_FILE, 7'h20, 3'h0, bbo_pkg::DEST_ACC, 8'h00);
    chk("add file acc", acc, 8'h41);
    chk("add file flags", flg(), 8'h02);
    rd_bus(8'h20, v);
    chk("add file kept", v, 8'h28);
    op(bbo_pkg::OP_ADD_FILE, 7'h20, 3'h0, bbo_pkg::DEST_FILE, 8'h00);
    rd_bus(8'h20, v);
    chk("add file dest", v, 8'h69);
    chk("add file acc kept", acc, 8'h41);
    // file and to each destination
    wr_bus(bbo_pkg::ADDR_ACC, 8'h96);
    wr_bus(bbo_pkg::ADDR_STATUS, 8'h03);
    op(bbo_pkg::OP_AND_FILE, 7'h20, 3'h0, bbo_pkg::DEST_FILE, 8'h00);
    rd_bus(8'h20, v);
    chk("and file dest", v, 8'h00);
    chk("and file flags", flg(), 8'h07);
    wr_bus(8'h21, 8'hF3);
    op(bbo_pkg::OP_AND_FILE, 7'h21, 3'h0, bbo_pkg::DEST_ACC, 8'h00);
    chk("and file acc", acc, 8'h92);
    chk("and file flags", flg(), 8'h03);
    // bit clear then bit set over every position, top file address
    wr_bus(bbo_pkg::ADDR_STATUS, 8'h05);
    wr_bus(8'h7F, 8'hFF);
    e = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      op(bbo_pkg::OP_BIT_CLR, 7'h7F, 3'(b), bbo_pkg::DEST_ACC, 8'h00);
      e = e & ~(8'h01 << b);
      rd_bus(8'h7F, v);
      chk("bit clear", v, e);
    end
    for (int b = 7; b >= 0; b--) begin
      op(bbo_pkg::OP_BIT_SET, 7'h7F, 3'(b), bbo_pkg::DEST_ACC, 8'h00);
      e = e | (8'h01 << b);
      rd_bus(8'h7F, v);
      chk("bit set", v, e);
    end
    chk("bit op flags", flg(), 8'h05);
    // test and skip
    wr_bus(8'h30, 8'h04);
    wr_bus(bbo_pkg::ADDR_ACC, 8'h10);
    op(bbo_pkg::OP_BIT_TEST, 7'h30, 3'h2, bbo_pkg::DEST_ACC, 8'h00);
    chk("no skip", {7'h00, skip}, 8'h00);
    op(bbo_pkg::OP_ADD_LIT, 7'h00, 3'h0, bbo_pkg::DEST_ACC, 8'h01);
    chk("executed", acc, 8'h11);
    wr_bus(bbo_pkg::ADDR_STATUS, 8'h07);
    op(bbo_pkg::OP_BIT_TEST, 7'h30, 3'h0, bbo_pkg::DEST_ACC, 8'h00);
    chk("skip set", {7'h00, skip}, 8'h01);
    op(bbo_pkg::OP_ADD_LIT, 7'h00, 3'h0, bbo_pkg::DEST_ACC, 8'h01);
    chk("discarded", acc, 8'h11);
    chk("skip clear", {7'h00, skip}, 8'h00);
    chk("test flags", flg(), 8'h07);
    // i/o read-modify-write takes the pins
    @(posedge mclk);
    io_pins <= 8'hA5;
    wr_bus(8'h05, 8'hFF);
    chk("latch write", io_latch, 8'hFF);
    repeat (3) @(posedge mclk);
    op(bbo_pkg::OP_BIT_SET, 7'h05, 3'h1, bbo_pkg::DEST_ACC, 8'h00);
    chk("io rmw", io_latch, 8'hA7);
    wr_bus(bbo_pkg::ADDR_ACC, 8'h0F);
    op(bbo_pkg::OP_AND_FILE, 7'h05, 3'h0, bbo_pkg::DEST_FILE, 8'h00);
    chk("io and", io_latch, 8'h05);
    chk("io and acc kept", acc, 8'h0F);
    op(bbo_pkg::OP_ADD_FILE, 7'h05, 3'h0, bbo_pkg::DEST_FILE, 8'h00);
    chk("io add", io_latch, 8'hB4);
    chk("io add flags", flg(), 8'h02);
    op(bbo_pkg::OP_BIT_CLR, 7'h05, 3'h0, bbo_pkg::DEST_ACC, 8'h00);
    chk("io clear", io_latch, 8'hA4);
    // timer write back clears an assigned prescaler
    wr_bus(bbo_pkg::ADDR_CFG, 8'h01);
    rd_bus(bbo_pkg::ADDR_CFG, v);
    chk("cfg read", v, 8'h01);
    wr_bus(8'h01, 8'h40);
    op(bbo_pkg::OP_BIT_SET, 7'h01, 3'h0, bbo_pkg::DEST_ACC, 8'h00);
    chk("timer rmw", timer, 8'h41);
    repeat (3) @(posedge mclk);
    #1;
    chk("prescaler cleared", timer, 8'h41);
    @(posedge mclk);
    #1;
    chk("timer tick", timer, 8'h42);
    summarize();
  end
endmodule // testbench
`default_nettype wire

// ==== bbo_file_ram.sv ====
// general-purpose file register array, one write port, two read ports
// assumes writes are already arbitrated by the caller
`timescale 1ns/1ps
`default_nettype none
module bbo_file_ram #(
  parameter int DEPTH = bbo_pkg::FILE_DEPTH,
  parameter int AW = bbo_pkg::FILE_AW,
  parameter int DW = bbo_pkg::DW
) (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [DW-1:0] o_rdata_a,
  output logic [DW-1:0] o_rdata_b
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata_a = mem[i_raddr_a];
  assign o_rdata_b = mem[i_raddr_b];

endmodule // bbo_file_ram
`default_nettype wire

// ==== bbo_pkg.sv ====
// shared types and constants of the byte/bit operation datapath
// assumes a single core clock; no tool-specific features
package bbo_pkg;

  localparam int DW = 8;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BUS_AW = 8;
  localparam int NIB_W = 4;
  localparam int PRESC_W_DEF = 8;

  // file register addresses with special behaviour
  localparam logic [FILE_AW-1:0] FILE_TIMER = 7'h01;
  localparam logic [FILE_AW-1:0] FILE_IO = 7'h05;

  // bus map above the file register space
  localparam logic [BUS_AW-1:0] ADDR_ACC = 8'h80;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h81;
  localparam logic [BUS_AW-1:0] ADDR_CFG = 8'h82;
  localparam int BUS_FILE_SEL = 7;

  // status and config bit positions
  localparam int STAT_C = 0;
  localparam int STAT_DCARRY = 1;
  localparam int STAT_Z = 2;
  localparam int CFG_PSA = 0;

  localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [DW-1:0] IO_LATCH_RST = 8'h00;
  localparam logic [DW-1:0] TIMER_RST = 8'h00;
  localparam logic [DW-1:0] BIT0 = 8'h01;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_ADD_LIT  = 3'b001,
    OP_AND_LIT  = 3'b010,
    OP_ADD_FILE = 3'b011,
    OP_AND_FILE = 3'b100,
    OP_BIT_CLR  = 3'b101,
    OP_BIT_SET  = 3'b110,
    OP_BIT_TEST = 3'b111
  } bbo_op_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'b00,
    ALU_AND = 2'b01,
    ALU_CLR = 2'b10,
    ALU_SET = 2'b11
  } bbo_alu_op_t;

  typedef struct packed {
    bbo_op_t op;
    logic [FILE_AW-1:0] addr;
    logic [2:0] bit_sel;
    logic dest;
    logic [DW-1:0] literal;
  } bbo_cmd_t;

  typedef struct packed {
    logic [DW-1:0] res;
    logic carry;
    logic dcarry;
    logic zero;
  } bbo_alu_t;

endpackage
